/* File: logic/pcis_ctrl.sv */
// calibration sequencer and reference input selector
// assumes loss of signal and crystal flags come from async analog monitors
`include "pcis_defs.svh"
// Summary of operation
// - three-level straps decode to low, medium, high; floating reads medium
// - four plan straps set the multiplication ratio for both outputs
// - bandwidth code from two bandwidth straps plus table strap
// - alarm held and loop driven by sequencer while calibrating
// - calibrate on reset, reset release, strap change, range fault
// - calibration waits for valid active input and crystal present
// - free-running output clock enabled while waiting for input
// - no recalibration after success without a trigger event
// - input loss enters holdover; return relocks without calibration
// - drift of 500 ppm since calibration may trigger recalibration
// - logic stays in reset until a valid reference appears
// - switch adopts new input phase offset, no output step
// - alarm may pulse on switch between inputs over 100 ppm apart
// - mode medium or high selects automatic; choice pin reports choice
// - automatic priority fixed: input one above input two
// - at reset pick best valid input, else suppress outputs
// - revertive moves up on validity; non-revertive only on alarm
// - no valid input: holdover, then first input to become valid
module pcis_ctrl
   import pcis_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] freq_plan_select_hi,
   input wire logic [3:0] freq_plan_select_lo,
   input wire logic [1:0] loop_bw_select_hi,
   input wire logic [1:0] loop_bw_select_lo,
   input wire logic plan_table_select_hi,
   input wire logic plan_table_select_lo,
   input wire logic ref_source_select_hi,
   input wire logic ref_source_select_lo,
   input wire logic select_mode_pin_hi,
   input wire logic select_mode_pin_lo,
   input wire logic input_choice_pin_in,
   input wire logic signal_loss_alarm_one,
   input wire logic signal_loss_alarm_two,
   input wire logic xtal_present,
   input wire logic range_fault,
   input wire logic drift_exceeded,
   input wire logic freq_gap_large,
   output logic [7:0] plan_code,
   output logic [5:0] bw_code,
   output logic lock_lost_alarm,
   output logic cal_drive,
   output logic cal_active,
   output logic freerun_enable,
   output logic outputs_enable,
   output logic holdover,
   output logic active_is_two,
   output logic phase_capture,
   output logic input_choice_pin_out,
   output logic input_choice_pin_oe,
   output logic [1:0] state_code
);
   // ===========================================================
   // strap decoding
   // each pin has two comparators: above-high and below-low
   function automatic pcis_level_t lvl(input logic hi, input logic lo);
      // neither comparator tripped means the pin floats at mid supply
      lvl = hi ? `PCIS_LVL_HIGH : (lo ? `PCIS_LVL_LOW : `PCIS_LVL_MED);
   endfunction : lvl
   logic [`PCIS_STRAP_W-1:0] raw_pairs;
   logic [`PCIS_STRAP_W-1:0] strap_pairs;
   logic [`PCIS_STRAP_W-1:0] strap_lvls;
   logic strap_change;
   // pairs are synchronised before decoding so a mid-level pin cannot glitch it
   assign raw_pairs = {freq_plan_select_hi[3], freq_plan_select_lo[3],
                       freq_plan_select_hi[2], freq_plan_select_lo[2],
                       freq_plan_select_hi[1], freq_plan_select_lo[1],
                       freq_plan_select_hi[0], freq_plan_select_lo[0],
                       loop_bw_select_hi[1], loop_bw_select_lo[1],
                       loop_bw_select_hi[0], loop_bw_select_lo[0],
                       plan_table_select_hi, plan_table_select_lo,
                       ref_source_select_hi, ref_source_select_lo};
   for (genvar i = 0; i < 8; i++) begin : g_lvl
      assign strap_lvls[2*i+:2] = lvl(strap_pairs[2*i+1], strap_pairs[2*i]);
   end
   pcis_strap_filter u_filt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .raw_in(raw_pairs),
      .stable_out(strap_pairs),
      .change_pulse(strap_change)
   );
   // ===========================================================
   // async monitors
   logic [6:0] mon_meta_r;
   logic [6:0] mon_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         // reads as manual mode, both inputs lost: no false valid, no pin drive
         mon_meta_r <= 7'h2c;
         mon_r <= 7'h2c;
      end else begin
         mon_meta_r <= {select_mode_pin_hi, select_mode_pin_lo, input_choice_pin_in,
                        signal_loss_alarm_one, signal_loss_alarm_two, xtal_present,
                        range_fault};
         mon_r <= mon_meta_r;
      end
   end
   wire pcis_level_t mode = lvl(mon_r[6], mon_r[5]);
   wire choice_in = mon_r[4];
   wire valid_one = !mon_r[3];
   wire valid_two = !mon_r[2];
   wire xtal_ok = mon_r[1];
   wire fault = mon_r[0];
   wire auto_mode = (mode != `PCIS_LVL_LOW);
   wire revertive = (mode == `PCIS_LVL_HIGH);
   // ===========================================================
   // input selection
   logic sel_two_r;
   logic have_sel_r;
   logic prev_valid_one_r;
   logic prev_valid_two_r;
   logic sel_two_nxt;
   logic have_sel_nxt;
   wire any_valid = valid_one || valid_two;
   wire best_two = !valid_one;
   wire cur_valid = sel_two_r ? valid_two : valid_one;
   wire rise_one = valid_one && !prev_valid_one_r;
   wire rise_two = valid_two && !prev_valid_two_r;
   always_comb begin
      sel_two_nxt = sel_two_r;
      have_sel_nxt = have_sel_r;
      if (!auto_mode) begin
         sel_two_nxt = choice_in;
         have_sel_nxt = 1'b1;
      end else if (!have_sel_r) begin
         if (any_valid) begin
            sel_two_nxt = best_two;
            have_sel_nxt = 1'b1;
         end
      end else if (!cur_valid) begin
         if (any_valid) begin
            sel_two_nxt = best_two;
         end
      end else if (revertive && sel_two_r && valid_one) begin
         sel_two_nxt = 1'b0;
      end
      // holdover: first input that turns valid wins
      if (auto_mode && have_sel_r && !any_valid) begin
         sel_two_nxt = sel_two_r;
      end
      if (auto_mode && have_sel_r && !cur_valid && (rise_one || rise_two)) begin
         sel_two_nxt = rise_one ? 1'b0 : 1'b1;
      end
   end
   wire switching = have_sel_r && (sel_two_nxt != sel_two_r);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sel_two_r <= 1'b0;
         have_sel_r <= 1'b0;
         prev_valid_one_r <= 1'b0;
         prev_valid_two_r <= 1'b0;
      end else begin
         sel_two_r <= sel_two_nxt;
         have_sel_r <= have_sel_nxt;
         prev_valid_one_r <= valid_one;
         prev_valid_two_r <= valid_two;
      end
   end
   // a manual reference change is a strap change too, so it retriggers
   logic sel_src_r;
   wire src_change = have_sel_r && !auto_mode && (choice_in != sel_src_r);
   // ===========================================================
   // calibration sequencer
   pcis_state_t state_r;
   pcis_state_t state_nxt;
   logic cal_req_r;
   logic [15:0] cal_cnt_r;
   logic [15:0] hold_cnt_r;
   wire cal_done = (cal_cnt_r == 16'(`PCIS_CAL_CYC - 1));
   wire drift_trig = drift_exceeded && (state_r == PCIS_LOCKED);
   // set wins over the clear taken when calibration starts
   wire trig = strap_change || src_change || fault || drift_trig;
   wire inputs_ok = have_sel_r && cur_valid && xtal_ok;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         PCIS_RESET: begin
            if (any_valid) state_nxt = PCIS_WAIT;
         end
         PCIS_WAIT: begin
            if (inputs_ok) state_nxt = PCIS_CAL;
         end
         PCIS_CAL: begin
            if (!inputs_ok) state_nxt = PCIS_WAIT;
            else if (cal_done) state_nxt = PCIS_LOCKED;
         end
         PCIS_LOCKED: begin
            if (cal_req_r || trig) state_nxt = PCIS_WAIT;
            else if (!cur_valid) state_nxt = PCIS_HOLDOVER;
         end
         PCIS_HOLDOVER: begin
            if (cal_req_r || trig) state_nxt = PCIS_WAIT;
            else if (cur_valid) state_nxt = PCIS_LOCKED;
         end
         default: state_nxt = PCIS_RESET;
      endcase
   end
   wire cal_start = (state_r == PCIS_WAIT) && (state_nxt == PCIS_CAL);
   wire cal_req_nxt = trig ? 1'b1 : (cal_start ? 1'b0 : cal_req_r);
   wire [15:0] hold_nxt = (switching && freq_gap_large) ? `PCIS_HOLD_CYC :
                          ((hold_cnt_r != 16'h0000) ? hold_cnt_r - 16'h0001 : 16'h0000);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_r <= PCIS_RESET;
         cal_req_r <= 1'b1;
         cal_cnt_r <= 16'h0000;
         hold_cnt_r <= 16'h0000;
         sel_src_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cal_req_r <= cal_req_nxt;
         cal_cnt_r <= (state_r == PCIS_CAL) ? cal_cnt_r + 16'h0001 : 16'h0000;
         hold_cnt_r <= hold_nxt;
         sel_src_r <= choice_in;
      end
   end
   // ===========================================================
   // registered outputs
   wire in_cal = (state_nxt == PCIS_CAL);
   wire running = (state_nxt == PCIS_LOCKED) || (state_nxt == PCIS_HOLDOVER);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         plan_code <= 8'h00;
         bw_code <= 6'h00;
         lock_lost_alarm <= 1'b1;
         cal_drive <= 1'b0;
         cal_active <= 1'b0;
         freerun_enable <= 1'b0;
         outputs_enable <= 1'b0;
         holdover <= 1'b0;
         active_is_two <= 1'b0;
         phase_capture <= 1'b0;
         input_choice_pin_out <= 1'b0;
         input_choice_pin_oe <= 1'b0;
         state_code <= 2'h0;
      end else begin
         plan_code <= strap_lvls[15:8];
         bw_code <= strap_lvls[7:2];
         lock_lost_alarm <= in_cal || !running || (hold_nxt != 16'h0000);
         cal_drive <= in_cal;
         cal_active <= in_cal;
         // vco range set by plan and table; frequency is loose until calibrated
         freerun_enable <= (state_nxt == PCIS_WAIT) && have_sel_nxt;
         outputs_enable <= have_sel_nxt && (state_nxt != PCIS_RESET);
         holdover <= (state_nxt == PCIS_HOLDOVER);
         active_is_two <= sel_two_nxt;
         phase_capture <= switching;
         input_choice_pin_out <= sel_two_nxt;
         input_choice_pin_oe <= auto_mode;
         state_code <= state_nxt[1:0];
      end
   end
endmodule : pcis_ctrl

/* File: logic/pcis_defs.svh */
// constants for the calibration and input select control logic
// assumes a 200 MHz core clock and already qualified alarm inputs
`ifndef PCIS_DEFS_SVH
`define PCIS_DEFS_SVH
`define PCIS_CLK_MHZ 200
`define PCIS_STRAP_STABLE_CYC 16
`define PCIS_CAL_TIME_US 10
`define PCIS_CAL_CYC (`PCIS_CAL_TIME_US * `PCIS_CLK_MHZ)
`define PCIS_HOLD_CYC 16'd400
`define PCIS_DRIFT_PPM 500
`define PCIS_SWITCH_PPM 100
`define PCIS_LVL_LOW 2'h0
`define PCIS_LVL_MED 2'h1
`define PCIS_LVL_HIGH 2'h2
`define PCIS_NUM_STRAPS 8
`define PCIS_STRAP_W 16
`endif

/* File: logic/pcis_pkg.sv */
// types for the calibration and input select control logic
// assumes pcis_defs.svh is on the include path
`include "pcis_defs.svh"
package pcis_pkg;
   typedef enum logic [2:0] {
      PCIS_RESET = 3'h0,
      PCIS_WAIT = 3'h1,
      PCIS_CAL = 3'h2,
      PCIS_LOCKED = 3'h3,
      PCIS_HOLDOVER = 3'h4
   } pcis_state_t;
   typedef logic [1:0] pcis_level_t;
endpackage : pcis_pkg

/* File: logic/pcis_strap_filter.sv */
// synchroniser and stability filter for the strap comparator pairs
// assumes raw strap comparator outputs are asynchronous to core_clk
`include "pcis_defs.svh"
module pcis_strap_filter
   import pcis_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [`PCIS_STRAP_W-1:0] raw_in,
   output logic [`PCIS_STRAP_W-1:0] stable_out,
   output logic change_pulse
);
   logic [`PCIS_STRAP_W-1:0] meta_r;
   logic [`PCIS_STRAP_W-1:0] sync_r;
   logic [`PCIS_STRAP_W-1:0] cand_r;
   logic [4:0] cnt_r;
   logic seen_r;
   wire differs = (sync_r != cand_r);
   wire settled = (cnt_r == 5'(`PCIS_STRAP_STABLE_CYC));
   wire take = settled && (cand_r != stable_out);
   // ===========================================================
   // sync and settle
   // slow pin edges glitch through midlevel; the count hides them
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
         cand_r <= '0;
         cnt_r <= '0;
         stable_out <= '0;
         change_pulse <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         meta_r <= raw_in;
         sync_r <= meta_r;
         cand_r <= sync_r;
         cnt_r <= differs ? 5'h00 : (settled ? cnt_r : cnt_r + 5'h01);
         if (take) begin
            stable_out <= cand_r;
         end
         // straps equal to the reset value must still arm the detector
         if (settled) begin
            seen_r <= 1'b1;
         end
         // first settle after reset is not a change
         change_pulse <= take && seen_r;
      end
   end
endmodule : pcis_strap_filter

/* File: test/pcis_board_model.sv */
// board side: strap resistors, reference monitors and choice pin wiring
// assumes strap levels come from the bench in the package level encoding
`include "pcis_defs.svh"
module pcis_board_model
   import pcis_pkg::*;
(
   input wire logic [7:0] plan_lvl,
   input wire logic [3:0] bw_lvl,
   input wire logic [1:0] table_lvl,
   input wire logic [1:0] src_lvl,
   input wire logic [1:0] mode_lvl,
   input wire logic manual_two,
   input wire logic one_ok,
   input wire logic two_ok,
   input wire logic xtal_ok,
   input wire logic input_choice_pin_out,
   input wire logic input_choice_pin_oe,
   output logic [3:0] freq_plan_select_hi,
   output logic [3:0] freq_plan_select_lo,
   output logic [1:0] loop_bw_select_hi,
   output logic [1:0] loop_bw_select_lo,
   output logic plan_table_select_hi,
   output logic plan_table_select_lo,
   output logic ref_source_select_hi,
   output logic ref_source_select_lo,
   output logic select_mode_pin_hi,
   output logic select_mode_pin_lo,
   output logic input_choice_pin_in,
   output logic signal_loss_alarm_one,
   output logic signal_loss_alarm_two,
   output logic xtal_present
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // three-level straps
   wire [17:0] lvl = {mode_lvl, src_lvl, table_lvl, bw_lvl, plan_lvl};
   wire [8:0] hi;
   wire [8:0] lo;
   for (genvar i = 0; i < 9; i++) begin : g_strap
      // floating pin trips neither comparator
      assign hi[i] = lvl[2*i+:2] == `PCIS_LVL_HIGH;
      assign lo[i] = lvl[2*i+:2] == `PCIS_LVL_LOW;
   end
   assign {select_mode_pin_hi, ref_source_select_hi, plan_table_select_hi, loop_bw_select_hi,
      freq_plan_select_hi} = hi;
   assign {select_mode_pin_lo, ref_source_select_lo, plan_table_select_lo, loop_bw_select_lo,
      freq_plan_select_lo} = lo;
   // ==========================================
   // references and shared choice pin
   assign input_choice_pin_in = input_choice_pin_oe ? input_choice_pin_out : manual_two;
   assign signal_loss_alarm_one = !one_ok;
   assign signal_loss_alarm_two = !two_ok;
   assign xtal_present = xtal_ok;
endmodule : pcis_board_model

/* File: test/pcis_ctrl_assertions.sv */
// checker for the calibration sequencer and input selector ports
// assumes a bind from the bench top onto pcis_ctrl
`include "pcis_defs.svh"
module pcis_ctrl_assertions
   import pcis_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic xtal_present,
   input wire logic lock_lost_alarm,
   input wire logic cal_drive,
   input wire logic cal_active,
   input wire logic freerun_enable,
   input wire logic outputs_enable,
   input wire logic holdover,
   input wire logic phase_capture,
   input wire logic [1:0] state_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // calibration length counter
   localparam int CAL_LO = `PCIS_CAL_CYC - 1;
   localparam int CAL_HI = `PCIS_CAL_CYC + 1;
   logic [11:0] cal_cnt_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge core_clk) begin
      cal_cnt_r <= (!rst_n || !cal_active) ? 12'h0 : cal_cnt_r + 12'h1;
   end
   // ==========================================
   // properties
   chk_alarm_in_cal: assert property (cal_active |-> lock_lost_alarm && cal_drive)
      else $error("alarm or drive low during calibration");
   chk_cal_from_wait: assert property ($rose(cal_active) |-> $past(state_code) == 2'h1)
      else $error("calibration entered from a state other than wait");
   // raw flag passes a synchroniser, so look back far enough
   chk_xtal_gate: assert property (!xtal_present [*6] |-> !$rose(cal_active))
      else $error("calibration started without reference oscillator");
   chk_cal_length: assert property ($fell(cal_active) && state_code == 2'h3
      |-> cal_cnt_r >= CAL_LO && cal_cnt_r <= CAL_HI)
      else $error("calibration length wrong");
   chk_cal_bound: assert property (cal_cnt_r <= CAL_HI)
      else $error("calibration overran");
   chk_hold_no_cal: assert property (holdover |-> !cal_active && state_code == 2'h0)
      else $error("calibration during holdover");
   chk_capture_pulse: assert property (phase_capture |=> !phase_capture)
      else $error("phase capture longer than one cycle");
   chk_wait_freerun: assert property (state_code == 2'h1 |-> freerun_enable)
      else $error("no free running clock while waiting");
   chk_reset_quiet: assert property (state_code == 2'h0 && !holdover
      |-> !outputs_enable && lock_lost_alarm)
      else $error("outputs on or alarm off in reset state");
endmodule : pcis_ctrl_assertions

/* File: test/testbench.sv */
// self-checking bench for the calibration sequencer and input selector
// assumes pcis_ctrl, the board model and the checker are compiled first
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_n = 1'b0;
   logic [7:0] plan_lvl = 8'h92;
   logic [3:0] bw_lvl = 4'h2;
   logic [1:0] table_lvl = 2'h1, src_lvl = 2'h0, mode_lvl = 2'h0;
   logic manual_two = 1'b0, one_ok = 1'b0, two_ok = 1'b0, xtal_ok = 1'b0;
   logic range_fault = 1'b0, drift_exceeded = 1'b0, freq_gap_large = 1'b0;
   wire [3:0] freq_plan_select_hi, freq_plan_select_lo;
   wire [1:0] loop_bw_select_hi, loop_bw_select_lo, state_code;
   wire plan_table_select_hi, plan_table_select_lo, ref_source_select_hi, ref_source_select_lo;
   wire select_mode_pin_hi, select_mode_pin_lo, input_choice_pin_in, xtal_present;
   wire signal_loss_alarm_one, signal_loss_alarm_two, lock_lost_alarm, cal_drive, cal_active;
   wire freerun_enable, outputs_enable, holdover, active_is_two, phase_capture;
   wire input_choice_pin_out, input_choice_pin_oe;
   wire [7:0] plan_code;
   wire [5:0] bw_code;
   int miscompares = 0, checks_done = 0, cycles = 0, captures = 0, alarm_hits = 0;
   pcis_board_model board (.plan_lvl, .bw_lvl, .table_lvl, .src_lvl, .mode_lvl, .manual_two,
      .one_ok, .two_ok, .xtal_ok, .input_choice_pin_out, .input_choice_pin_oe,
      .freq_plan_select_hi, .freq_plan_select_lo, .loop_bw_select_hi, .loop_bw_select_lo,
      .plan_table_select_hi, .plan_table_select_lo, .ref_source_select_hi,
      .ref_source_select_lo, .select_mode_pin_hi, .select_mode_pin_lo, .input_choice_pin_in,
      .signal_loss_alarm_one, .signal_loss_alarm_two, .xtal_present);
   pcis_ctrl dut (.core_clk, .rst_n, .freq_plan_select_hi, .freq_plan_select_lo,
      .loop_bw_select_hi, .loop_bw_select_lo, .plan_table_select_hi, .plan_table_select_lo,
      .ref_source_select_hi, .ref_source_select_lo, .select_mode_pin_hi, .select_mode_pin_lo,
      .input_choice_pin_in, .signal_loss_alarm_one, .signal_loss_alarm_two, .xtal_present,
      .range_fault, .drift_exceeded, .freq_gap_large, .plan_code, .bw_code, .lock_lost_alarm,
      .cal_drive, .cal_active, .freerun_enable, .outputs_enable, .holdover, .active_is_two,
      .phase_capture, .input_choice_pin_out, .input_choice_pin_oe, .state_code);
   // ==========================================
   // tasks
   task automatic check_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0b seen %0b", what, exp, got);
      end
   endtask : check_bit
   task automatic check_code(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check_code
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : idle
   // bounded wait, then the state is compared either way
   task automatic wait_state(input logic [1:0] code, input int lim);
      int n;
      n = 0;
      while (state_code !== code && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      check_code("state_code", {6'h0, code}, {6'h0, state_code});
   endtask : wait_state
   task automatic wrap_up;
      if (miscompares == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   // ==========================================
   // clock, monitors, timeout
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (phase_capture === 1'b1) captures++;
      if (lock_lost_alarm === 1'b1 && state_code === 2'h3) alarm_hits++;
      if (cycles == 40000) begin
         miscompares++;
         wrap_up();
      end
   end
   // ==========================================
   // scenarios
   initial begin
      idle(2);
      check_bit("lock_lost_alarm", 1'b1, lock_lost_alarm);
      rst_n = 1'b1;
      idle(30);
      wait_state(2'h0, 0);
      check_bit("outputs_enable", 1'b0, outputs_enable);
      one_ok = 1'b1;
      wait_state(2'h1, 10);
      idle(20);
      wait_state(2'h1, 0);
      check_bit("freerun_enable", 1'b1, freerun_enable);
      xtal_ok = 1'b1;
      wait_state(2'h2, 10);
      check_bit("lock_lost_alarm", 1'b1, lock_lost_alarm);
      wait_state(2'h3, 2100);
      check_bit("lock_lost_alarm", 1'b0, lock_lost_alarm);
      check_code("plan_code", 8'h92, plan_code);
      check_code("bw_code", 8'h09, {2'h0, bw_code});
      bw_lvl = 4'h1;
      idle(5);
      bw_lvl = 4'h2;
      idle(100);
      wait_state(2'h3, 0);
      for (int k = 0; k < 3; k++) begin
         if (k == 0) bw_lvl = 4'h1;
         if (k == 1) src_lvl = 2'h2;
         if (k == 2) plan_lvl = 8'h96;
         wait_state(2'h2, 60);
         wait_state(2'h3, 2100);
      end
      check_code("bw_code", 8'h05, {2'h0, bw_code});
      check_code("plan_code", 8'h96, plan_code);
      for (int k = 0; k < 2; k++) begin
         {drift_exceeded, range_fault} = k ? 2'b10 : 2'b01;
         idle(1);
         {drift_exceeded, range_fault} = 2'b00;
         wait_state(2'h2, 20);
         wait_state(2'h3, 2100);
      end
      one_ok = 1'b0;
      idle(10);
      check_bit("holdover", 1'b1, holdover);
      one_ok = 1'b1;
      wait_state(2'h3, 10);
      two_ok = 1'b1;
      manual_two = 1'b1;
      wait_state(2'h2, 60);
      wait_state(2'h3, 2100);
      check_bit("active_is_two", 1'b1, active_is_two);
      check_bit("input_choice_pin_oe", 1'b0, input_choice_pin_oe);
      for (int k = 0; k < 2; k++) begin
         // revertive first, then non-revertive
         mode_lvl = k ? 2'h1 : 2'h2;
         // long enough for any earlier switch alarm to run out
         idle(450);
         // the mode pin is not a calibration trigger
         wait_state(2'h3, 0);
         check_bit("cal_active", 1'b0, cal_active);
         check_bit("lock_lost_alarm", 1'b0, lock_lost_alarm);
         check_bit("input_choice_pin_oe", 1'b1, input_choice_pin_oe);
         check_bit("input_choice_pin_out", 1'b0, input_choice_pin_out);
         freq_gap_large = 1'b1;
         captures = 0;
         alarm_hits = 0;
         one_ok = 1'b0;
         idle(10);
         check_bit("active_is_two", 1'b1, active_is_two);
         check_bit("phase_capture", 1'b1, captures > 0);
         check_bit("lock_lost_alarm", 1'b1, alarm_hits > 0);
         freq_gap_large = 1'b0;
         one_ok = 1'b1;
         idle(10);
         check_bit("active_is_two", k[0], active_is_two);
      end
      one_ok = 1'b0;
      two_ok = 1'b0;
      idle(10);
      check_bit("holdover", 1'b1, holdover);
      two_ok = 1'b1;
      idle(10);
      check_bit("active_is_two", 1'b1, active_is_two);
      check_bit("holdover", 1'b0, holdover);
      wrap_up();
   end
endmodule : testbench
bind pcis_ctrl pcis_ctrl_assertions u_chk (.core_clk, .rst_n, .xtal_present, .lock_lost_alarm,
   .cal_drive, .cal_active, .freerun_enable, .outputs_enable, .holdover, .phase_capture,
   .state_code);
